/* File: bench/pbsr_regs_assertions.sv */
`timescale 1ns/100ps
`default_nettype none
module pbsr_checker (
   input wire logic        core_clk,
   input wire logic        reset,
   input wire logic        hot_reset,
   input wire logic        cfg_wr,
   input wire logic        cfg_rd,
   input wire logic        cfg_ack,
   input wire logic        system_allocated_flag,
   input wire logic        budget_data_unlock,
   input wire logic        global_register_unlock,
   input wire logic [11:0] cfg_addr,
   input wire logic [31:0] cfg_rdata,
   input wire logic [3:0]  elastic_fifo_initial_value
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);
   sequence s_rd(a);
      cfg_rd && !hot_reset && cfg_addr == a;
   endsequence
   chk_ack_follows: assert property ((cfg_wr || cfg_rd) && !hot_reset |=> cfg_ack) else $error("no ack");
   chk_no_stray: assert property (!(cfg_wr || cfg_rd) |=> !cfg_ack) else $error("stray ack");
   chk_wr_zero: assert property (cfg_wr |=> cfg_rdata == 32'h0) else $error("write returned data");
   chk_cap_read: assert property (s_rd(12'h28C) |=> cfg_rdata == {31'h0, $past(system_allocated_flag)})
      else $error("capability read wrong");
   chk_sts_reserved: assert property (s_rd(12'h328) |=> cfg_rdata[27:23] == 5'h0 &&
      cfg_rdata[19:10] == 10'h0 && cfg_rdata[4:3] == 2'h0) else $error("status reserved bits set");
   chk_efifo_mode: assert property (s_rd(12'h328) |=> elastic_fifo_initial_value == (cfg_rdata[1] ? 4'h2 : 4'h4))
      else $error("fifo value wrong");
   chk_hot_unlock: assert property (hot_reset |=> global_register_unlock) else $error("unlock not set");
   chk_sa_locked: assert property (cfg_wr && !global_register_unlock |=> $stable(system_allocated_flag))
      else $error("locked flag changed");
   chk_bdu_locked: assert property (cfg_wr && !global_register_unlock |=> $stable(budget_data_unlock))
      else $error("locked data unlock changed");
endmodule
bind pbsr_regs pbsr_checker pbsr_checker_i (.*);
`default_nettype wire

/* File: bench/pbsr_regs_bench.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin num_errors++; \
   $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module pbsr_regs_bench;
   logic        core_clk, reset, hot_reset, cfg_wr, cfg_rd, cfg_ack, system_allocated_flag;
   logic        budget_data_unlock, global_register_unlock, downstream_common_clock_strap;
   logic        upstream_common_clock_strap, master_serial_slow_strap, reference_clock_mode_strap, reset_halt_strap;
   logic [2:0]  mode_pins, upstream_lock_state;
   logic [3:0]  elastic_fifo_initial_value;
   logic [4:0]  st, sp;
   logic [11:0] cfg_addr;
   logic [31:0] cfg_wdata, cfg_rdata, d, ex, seed = 32'h9BA4, v[10], qv[$];
   int          num_errors = 0, cmp_count = 0;
   assign {reset_halt_strap, reference_clock_mode_strap, master_serial_slow_strap,
           upstream_common_clock_strap, downstream_common_clock_strap} = sp;
   pbsr_regs pbsr_regs_i (.*);
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [31:0] sts(logic [3:0] mk, logic [2:0] lk, logic [2:0] m);
      return {mk, 5'h0, lk, 10'h0, st, 2'h0, m};
   endfunction
   // one access per cycle; strobe stays up for back-to-back use
   task automatic acc(logic w, logic [11:0] a, logic [31:0] dd, logic [31:0] e);
      cfg_wr = w;
      cfg_rd = !w;
      cfg_addr = a;
      cfg_wdata = dd;
      qv.push_back(w ? 32'h0 : e);
      @(negedge core_clk);
   endtask
   task automatic idle();
      cfg_wr = 0;
      cfg_rd = 0;
      @(negedge core_clk);
   endtask
   task automatic wrap_up();
      $display("errors=%0d compares=%0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      core_clk = 0;
      forever #50 core_clk = ~core_clk;
   end
   always @(negedge core_clk) begin
      if (cfg_ack === 1'b1) begin
         ex = qv.size() ? qv.pop_front() : 32'hX;
         `CHK(cfg_rdata, ex)
      end
   end
   initial begin
      #300000;
      num_errors++;
      wrap_up();
   end
   initial begin
      {cfg_wr, cfg_rd, hot_reset, cfg_addr, cfg_wdata, upstream_lock_state} = '0;
      for (int m = 0; m < 4; m++) begin
         reset = 1;
         mode_pins = m[2:0];
         st = 5'(xs()) | {3'h0, m[1], m[1]};
         sp = st;
         repeat (10) @(negedge core_clk);
         reset = 0;
         mode_pins = 3'(xs());
         sp = 5'(xs());
         acc(0, 12'h328, 0, sts(4'h0, 3'h0, m[2:0]));
         acc(0, 12'h28C, 0, 0);
         idle();
      end
      acc(1, 12'h28C, 32'hFFFFFFFF, 0);
      acc(0, 12'h28C, 0, 32'h1);
      acc(1, 12'h328, 32'hFFFFFFFF, 0);
      acc(0, 12'h328, 0, sts(4'hF, 3'h0, 3'h3));
      for (int p = 0; p < 2; p++) begin
         acc(1, 12'h32C, p ? 32'h8 : 32'hFFFFFFFF, 0);
         for (int i = 0; i < 10; i++) begin
            d = xs();
            acc(1, 12'h300 + 12'(i * 4), d, 0);
            if (p == 0) v[i] = d;
         end
         for (int i = 0; i < 10; i++) acc(0, 12'h300 + 12'(i * 4), 0, v[i]);
      end
      acc(1, 12'h32C, 32'h0, 0);
      acc(1, 12'h28C, 32'h0, 0);
      acc(1, 12'h328, 32'h0, 0);
      acc(1, 12'h32C, 32'h10, 0);
      acc(0, 12'h28C, 0, 32'h1);
      acc(0, 12'h32C, 0, 32'h0);
      for (int k = 2; k < 6; k++) begin
         upstream_lock_state = k[2:0];
         idle();
         acc(0, 12'h328, 0, sts(4'hF, k[2:0], 3'h3));
      end
      upstream_lock_state = 3'h0;
      hot_reset = 1;
      idle();
      hot_reset = 0;
      acc(0, 12'h32C, 0, 32'h8);
      acc(0, 12'h328, 0, sts(4'hF, 3'h0, 3'h3));
      acc(0, 12'h28C, 0, 32'h1);
      acc(0, 12'h300, 0, v[0]);
      acc(0, 12'h33C, 0, 0);
      idle();
      idle();
      wrap_up();
   end
endmodule
`default_nettype wire

/* File: hdl/pbsr_map.vh */
`ifndef PBSR_MAP_VH
`define PBSR_MAP_VH
`define PBSR_OFS_CAPABILITY   12'h28C
`define PBSR_OFS_DATA_BASE    12'h300
`define PBSR_DATA_WORDS       10
`define PBSR_OFS_STATUS       12'h328
`define PBSR_OFS_CONTROL      12'h32C
`define PBSR_SA_BIT           0
`define PBSR_MODE_LSB         0
`define PBSR_MODE_MSB         2
`define PBSR_STRAP_LSB        5
`define PBSR_STRAP_MSB        9
`define PBSR_LOCK_LSB         20
`define PBSR_LOCK_MSB         22
`define PBSR_MARKER_LSB       28
`define PBSR_MARKER_MSB       31
`define PBSR_REG_UNLOCK_BIT   3
`define PBSR_DATA_UNLOCK_BIT  4
`define PBSR_LOWLAT_MODE_BIT  1
`define PBSR_RST_MARKER       4'h0
`define PBSR_RST_LOCK         3'h0
`define PBSR_RST_MODE         3'h0
`define PBSR_RST_STRAPS       5'h00
`endif

/* File: hdl/pbsr_regs.v */
`timescale 1ns/100ps
`default_nettype none
`include "pbsr_map.vh"

// Summary of operation
// - bit 0 of the capability register is a sticky lockable flag saying the device power is already in the system budget.
// - ten sticky 32-bit data words, indices 0 to 9, sit from the base offset with undefined reset contents.
// - the data words can always be read, but written only while the data unlock bit is set.
// - with the data unlock bit clear, writes to the data words are dropped and contents stay unchanged.
// - status bits 2:0 show the operating mode latched from the mode pins, values above 3 reserved.
// - in either lower-latency mode a different elastic FIFO initial value is used, saving 8 ns.
// - five straps captured during fundamental reset appear as read-only status bits 5 to 9.
// - status bits 22:20 report the upstream lock state, reset to zero.
// - status bits 31:28 are a sticky lockable marker, reset to zero and unchanged by hot reset.
// - bit 4 of switch control is the sticky lockable data unlock bit governing data word writes.
// - lockable fields are read-only while bit 3 of switch control is clear, and that bit is set during any reset.
module pbsr_regs #(
   parameter             EFIFO_W         = 4,
   parameter [EFIFO_W-1:0] EFIFO_NORMAL_IV = 4'h4,
   parameter [EFIFO_W-1:0] EFIFO_LOWLAT_IV = 4'h2
) (
   input  wire                core_clk,
   input  wire                reset,
   input  wire                hot_reset,
   input  wire                cfg_wr,
   input  wire                cfg_rd,
   input  wire [11:0]         cfg_addr,
   input  wire [31:0]         cfg_wdata,
   output reg  [31:0]         cfg_rdata,
   output reg                 cfg_ack,
   input  wire [2:0]          mode_pins,
   input  wire                downstream_common_clock_strap,
   input  wire                upstream_common_clock_strap,
   input  wire                master_serial_slow_strap,
   input  wire                reference_clock_mode_strap,
   input  wire                reset_halt_strap,
   input  wire [2:0]          upstream_lock_state,
   output reg                 system_allocated_flag,
   output reg                 budget_data_unlock,
   output reg                 global_register_unlock,
   output reg  [EFIFO_W-1:0]  elastic_fifo_initial_value
);

   reg  [7:0]         pins_s1_q;
   reg  [7:0]         pins_s2_q;
   reg  [2:0]         mode_q;
   reg  [2:0]         mode_d;
   reg  [4:0]         straps_q;
   reg  [4:0]         straps_d;
   reg  [2:0]         lock_q;
   reg  [2:0]         lock_d;
   reg  [3:0]         marker_q;
   reg  [3:0]         marker_d;
   reg                sa_d;
   reg                reg_unlock_d;
   reg                data_unlock_d;
   reg  [EFIFO_W-1:0] efifo_d;
   reg                ack_d;
   reg  [31:0]        rdata_d;
   reg  [31:0]        data_q [0:`PBSR_DATA_WORDS-1];
   reg  [31:0]        rd_d;
   reg  [11:0]        data_ofs;
   reg  [3:0]         data_idx;
   reg                data_hit;
   reg                wr_taken;
   reg                lockable_wr;
   reg                data_wr;
   integer            i;

   // word index of an address inside the data window
   function [3:0] word_idx;
      input [11:0] ofs;
      begin
         word_idx = ofs[5:2];
      end
   endfunction

   // exact match of one register offset
   function reg_hit;
      input [11:0] addr;
      input [11:0] ofs;
      begin
         reg_hit = (addr == ofs);
      end
   endfunction

   always @* begin
      data_ofs    = cfg_addr - `PBSR_OFS_DATA_BASE;
      data_idx    = word_idx(data_ofs);
      data_hit    = (cfg_addr >= `PBSR_OFS_DATA_BASE) && (data_ofs[11:6] == 6'h00)
                    && (data_ofs[1:0] == 2'h0) && (data_idx < `PBSR_DATA_WORDS);
      wr_taken    = cfg_wr & ~reset & ~hot_reset;
      // lockable fields only move while the global unlock is set
      lockable_wr = wr_taken & global_register_unlock;
      data_wr     = lockable_wr & budget_data_unlock & data_hit;
   end

   // pins cross into the core domain
   always @(posedge core_clk) begin
      pins_s1_q <= {mode_pins, downstream_common_clock_strap, upstream_common_clock_strap,
                    master_serial_slow_strap, reference_clock_mode_strap, reset_halt_strap};
      pins_s2_q <= pins_s1_q;
   end

   // straps and mode follow the pins while fundamental reset is held
   always @* begin
      if (reset) begin
         mode_d   = pins_s2_q[7:5];
         straps_d = {pins_s2_q[0], pins_s2_q[1], pins_s2_q[2], pins_s2_q[3], pins_s2_q[4]};
      end else begin
         mode_d   = mode_q;
         straps_d = straps_q;
      end
   end

   always @(posedge core_clk) begin
      mode_q   <= mode_d;
      straps_q <= straps_d;
   end

   always @* begin
      if (reset || hot_reset)
         lock_d = `PBSR_RST_LOCK;
      else
         lock_d = upstream_lock_state;
   end

   always @(posedge core_clk) begin
      lock_q <= lock_d;
   end

   // next values of the unlock bits, the flag and the marker
   always @* begin
      reg_unlock_d  = global_register_unlock;
      data_unlock_d = budget_data_unlock;
      sa_d          = system_allocated_flag;
      marker_d      = marker_q;
      if (reset) begin
         reg_unlock_d  = 1'h1;
         data_unlock_d = 1'h0;
         sa_d          = 1'h0;
         marker_d      = `PBSR_RST_MARKER;
      end else if (hot_reset) begin
         // sticky fields ride through a hot reset
         reg_unlock_d  = 1'h1;
      end else if (wr_taken) begin
         if (reg_hit(cfg_addr, `PBSR_OFS_CONTROL)) begin
            reg_unlock_d = cfg_wdata[`PBSR_REG_UNLOCK_BIT];
            if (lockable_wr)
               data_unlock_d = cfg_wdata[`PBSR_DATA_UNLOCK_BIT];
         end
         if (lockable_wr && reg_hit(cfg_addr, `PBSR_OFS_CAPABILITY))
            sa_d = cfg_wdata[`PBSR_SA_BIT];
         if (lockable_wr && reg_hit(cfg_addr, `PBSR_OFS_STATUS))
            marker_d = cfg_wdata[`PBSR_MARKER_MSB:`PBSR_MARKER_LSB];
      end
   end

   always @(posedge core_clk) begin
      global_register_unlock <= reg_unlock_d;
      budget_data_unlock     <= data_unlock_d;
      system_allocated_flag  <= sa_d;
      marker_q               <= marker_d;
   end

   // data words are sticky and have no reset
   always @(posedge core_clk) begin
      for (i = 0; i < `PBSR_DATA_WORDS; i = i + 1) begin
         if (data_wr && data_idx == i)
            data_q[i] <= cfg_wdata;
      end
   end

   // either lower-latency mode picks the shorter fill level
   always @* begin
      if (reset)
         efifo_d = EFIFO_NORMAL_IV;
      else if (mode_q[`PBSR_LOWLAT_MODE_BIT])
         efifo_d = EFIFO_LOWLAT_IV;
      else
         efifo_d = EFIFO_NORMAL_IV;
   end

   always @(posedge core_clk) begin
      elastic_fifo_initial_value <= efifo_d;
   end

   // reserved and unmapped space reads as zero
   always @* begin
      rd_d = 32'h00000000;
      if (reg_hit(cfg_addr, `PBSR_OFS_CAPABILITY))
         rd_d[`PBSR_SA_BIT] = system_allocated_flag;
      else if (reg_hit(cfg_addr, `PBSR_OFS_STATUS)) begin
         rd_d[`PBSR_MODE_MSB:`PBSR_MODE_LSB]     = mode_q;
         rd_d[`PBSR_STRAP_MSB:`PBSR_STRAP_LSB]   = straps_q;
         rd_d[`PBSR_LOCK_MSB:`PBSR_LOCK_LSB]     = lock_q;
         rd_d[`PBSR_MARKER_MSB:`PBSR_MARKER_LSB] = marker_q;
      end else if (reg_hit(cfg_addr, `PBSR_OFS_CONTROL)) begin
         rd_d[`PBSR_REG_UNLOCK_BIT]  = global_register_unlock;
         rd_d[`PBSR_DATA_UNLOCK_BIT] = budget_data_unlock;
      end else if (data_hit)
         rd_d = data_q[data_idx];
   end

   // read data only rides with its own ack
   always @* begin
      if (reset) begin
         ack_d   = 1'h0;
         rdata_d = 32'h00000000;
      end else begin
         ack_d   = cfg_rd | cfg_wr;
         rdata_d = cfg_rd ? rd_d : 32'h00000000;
      end
   end

   always @(posedge core_clk) begin
      cfg_ack   <= ack_d;
      cfg_rdata <= rdata_d;
   end

endmodule
`default_nettype wire
